// ===== design/spll_defines.svh
// constants of the secondary pll lock status block: offsets, fields, resets
// assumes a 32-bit avalon-mm slave with byte addresses = 4 * register index
//
// How it works
// - lock state reported in status bit 6
// - lock merges four enabled phase-loss indicators
// - fine detector counts only when enabled
// - no-activity counts only when enabled
// - frequency-limit hit counts only when enabled
// - coarse loss latches lock low until disabled
`ifndef SPLL_DEFINES_SVH
`define SPLL_DEFINES_SVH

`define SPLL_ADDR_W        10
// register indices; byte address is four times the index
`define SPLL_IDX_OPSTATUS  8'h09
`define SPLL_IDX_PHLOSS    8'h73
`define SPLL_IDX_COARSE    8'h74
`define SPLL_IDX_FREQLIM   8'h40
`define SPLL_IDX_IRQ_STAT  8'h80
`define SPLL_IDX_IRQ_MASK  8'h81

// field positions
`define SPLL_BIT_LOCK      6
`define SPLL_BIT_FINE_EN   7
`define SPLL_BIT_NOACT_EN  6
`define SPLL_BIT_COARSE_EN 7
`define SPLL_BIT_FLIM_EN   7
`define SPLL_BIT_IRQ_LOST  0
`define SPLL_BIT_IRQ_GAIN  1

// reset values
`define SPLL_RST_LOCK      1'b1
`define SPLL_RST_EN        1'b1
`define SPLL_RST_MASK      2'h0

`endif

// ===== design/spll_lock_status.sv
// secondary digital pll lock status with its enables, irq and avalon slave
// assumes the four phase-loss indicators are on clock_i, one word per access
`timescale 1ns/10ps
`default_nettype none
`include "spll_defines.svh"
module spll_lock_status
    import spll_pkg::*;
(
    input  wire logic                    clock_i,
    input  wire logic                    rst_b_i,
    input  wire logic [`SPLL_ADDR_W-1:0] address_i,
    input  wire logic                    read_i,
    input  wire logic                    write_i,
    input  wire logic [31:0]             writedata_i,
    output var  logic [31:0]             readdata_o,
    output var  logic                    waitrequest_o,
    input  wire logic                    fine_phase_loss_i,
    input  wire logic                    no_activity_i,
    input  wire logic                    freq_limit_i,
    input  wire logic                    coarse_phase_loss_i,
    output var  logic                    secondary_pll_locked_o,
    output var  logic                    irq_o
);
    spll_bus_e   bus_r;
    logic        fine_en_r;
    logic        noact_en_r;
    logic        coarse_en_r;
    logic        flim_en_r;
    logic [1:0]  irq_mask_r;
    logic [1:0]  irq_stat;
    logic        coarse_held;
    logic        lock_nxt;
    logic        req;
    logic        take;
    logic [7:0]  idx;
    spll_word_t  rdata_nxt;

    assign req  = read_i | write_i;
    assign take = req & (bus_r == SPLL_ACK);
    assign idx  = address_i[`SPLL_ADDR_W-1:2];

    // waitrequest is high on the first cycle of a request, low on the second
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_r         <= SPLL_IDLE;
            waitrequest_o <= 1'b1;
        end else begin
            case (bus_r)
                SPLL_IDLE: begin
                    if (req) begin
                        bus_r         <= SPLL_ACK;
                        waitrequest_o <= 1'b0;
                    end
                end
                SPLL_ACK: begin
                    bus_r         <= SPLL_IDLE;
                    waitrequest_o <= 1'b1;
                end
                default: begin
                    bus_r         <= SPLL_IDLE;
                    waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // enable controls and the irq mask, written through the slave
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fine_en_r   <= `SPLL_RST_EN;
            noact_en_r  <= `SPLL_RST_EN;
            coarse_en_r <= `SPLL_RST_EN;
            flim_en_r   <= `SPLL_RST_EN;
            irq_mask_r  <= `SPLL_RST_MASK;
        end else if (take && write_i) begin
            case (idx)
                `SPLL_IDX_PHLOSS: begin
                    fine_en_r  <= writedata_i[`SPLL_BIT_FINE_EN];
                    noact_en_r <= writedata_i[`SPLL_BIT_NOACT_EN];
                end
                `SPLL_IDX_COARSE:   coarse_en_r <= writedata_i[`SPLL_BIT_COARSE_EN];
                `SPLL_IDX_FREQLIM:  flim_en_r   <= writedata_i[`SPLL_BIT_FLIM_EN];
                `SPLL_IDX_IRQ_MASK: irq_mask_r  <= writedata_i[1:0];
                default: ;  // unmapped writes are dropped
            endcase
        end
    end

    // coarse loss is held until the detector is switched off
    spll_sticky u_coarse_hold (
        .clock_i   (clock_i),
        .rst_b_i   (rst_b_i),
        .rst_val_i (1'b0),
        .set_i     (coarse_en_r & coarse_phase_loss_i),
        .clr_i     (~coarse_en_r),
        .flag_o    (coarse_held)
    );

    // lock merges the four indicators, each gated by its enable
    always_comb begin
        lock_nxt = 1'b1;
        if (fine_en_r && fine_phase_loss_i) begin
            lock_nxt = 1'b0;
        end
        if (noact_en_r && no_activity_i) begin
            lock_nxt = 1'b0;
        end
        if (flim_en_r && freq_limit_i) begin
            lock_nxt = 1'b0;
        end
        // the hold is gated by the enable too, so disabling frees lock at once
        if (coarse_en_r && (coarse_held || coarse_phase_loss_i)) begin
            lock_nxt = 1'b0;
        end
    end

    // lock is registered once; the read path and the pin share it
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            secondary_pll_locked_o <= `SPLL_RST_LOCK;
        end else begin
            secondary_pll_locked_o <= lock_nxt;
        end
    end

    // lock lost and lock gained events, write one to clear
    spll_sticky u_irq_lost (
        .clock_i   (clock_i),
        .rst_b_i   (rst_b_i),
        .rst_val_i (1'b0),
        .set_i     (secondary_pll_locked_o & ~lock_nxt),
        .clr_i     (take & write_i & (idx == `SPLL_IDX_IRQ_STAT)
                    & writedata_i[`SPLL_BIT_IRQ_LOST]),
        .flag_o    (irq_stat[`SPLL_BIT_IRQ_LOST])
    );
    spll_sticky u_irq_gain (
        .clock_i   (clock_i),
        .rst_b_i   (rst_b_i),
        .rst_val_i (1'b0),
        .set_i     (~secondary_pll_locked_o & lock_nxt),
        .clr_i     (take & write_i & (idx == `SPLL_IDX_IRQ_STAT)
                    & writedata_i[`SPLL_BIT_IRQ_GAIN]),
        .flag_o    (irq_stat[`SPLL_BIT_IRQ_GAIN])
    );

    // level interrupt, registered so the pin never glitches
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask_r);
        end
    end

    // read mux; other fields of the status word are not this block's and read 0
    always_comb begin
        rdata_nxt = 32'h0;
        case (idx)
            `SPLL_IDX_OPSTATUS: rdata_nxt[`SPLL_BIT_LOCK] = secondary_pll_locked_o;
            `SPLL_IDX_PHLOSS: begin
                rdata_nxt[`SPLL_BIT_FINE_EN]  = fine_en_r;
                rdata_nxt[`SPLL_BIT_NOACT_EN] = noact_en_r;
            end
            `SPLL_IDX_COARSE:   rdata_nxt[`SPLL_BIT_COARSE_EN] = coarse_en_r;
            `SPLL_IDX_FREQLIM:  rdata_nxt[`SPLL_BIT_FLIM_EN]   = flim_en_r;
            `SPLL_IDX_IRQ_STAT: rdata_nxt[1:0] = irq_stat;
            `SPLL_IDX_IRQ_MASK: rdata_nxt[1:0] = irq_mask_r;
            default:            rdata_nxt = 32'h0;
        endcase
    end

    // data is loaded as waitrequest falls so it stands at the taking edge
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            readdata_o <= 32'h0;
        end else if (req && bus_r == SPLL_IDLE) begin
            readdata_o <= rdata_nxt;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_req_start;
        req && bus_r == SPLL_IDLE;
    endsequence
    sequence s_ack;
        !waitrequest_o ##1 waitrequest_o;
    endsequence

    a_bus_answer: assert property (s_req_start |=> s_ack)
        else $error("waitrequest did not answer in one cycle");
    a_lock_bit_read: assert property (
        (s_req_start and (read_i && idx == `SPLL_IDX_OPSTATUS))
        |=> readdata_o[`SPLL_BIT_LOCK] == $past(secondary_pll_locked_o))
        else $error("lock bit read wrong");
    a_top_bit_zero: assert property (
        !waitrequest_o && $past(idx) == `SPLL_IDX_OPSTATUS |-> readdata_o[7] == 1'b0)
        else $error("bit 7 not zero");
    a_fine_gate: assert property (
        fine_en_r && fine_phase_loss_i |=> !secondary_pll_locked_o)
        else $error("fine loss ignored");
    a_noact_gate: assert property (
        noact_en_r && no_activity_i |=> !secondary_pll_locked_o)
        else $error("no activity ignored");
    a_flim_gate: assert property (
        flim_en_r && freq_limit_i |=> !secondary_pll_locked_o)
        else $error("frequency limit ignored");
    a_coarse_hold: assert property (
        coarse_en_r && coarse_phase_loss_i ##1 coarse_en_r [*3]
        |-> !secondary_pll_locked_o)
        else $error("coarse loss not held");
    a_all_clear: assert property (
        !(fine_en_r && fine_phase_loss_i) && !(noact_en_r && no_activity_i)
        && !(flim_en_r && freq_limit_i) && !coarse_en_r
        |=> secondary_pll_locked_o)
        else $error("lock low with no cause");
    a_irq_level: assert property (
        |(irq_stat & irq_mask_r) |=> irq_o)
        else $error("interrupt not raised");
endmodule
`default_nettype wire

// ===== design/spll_pkg.sv
// types of the secondary pll lock status block
// assumes spll_defines.svh supplies all numbers
package spll_pkg;
    // bus access phase of the register slave
    typedef enum logic [1:0] {
        SPLL_IDLE = 2'h1,
        SPLL_ACK  = 2'h2
    } spll_bus_e;
    typedef logic [31:0] spll_word_t;
endpackage

// ===== design/spll_sticky.sv
// one sticky flag where a set in the clearing cycle wins
// assumes set and clear come from logic on clock_i
`timescale 1ns/10ps
`default_nettype none
module spll_sticky (
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic rst_val_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output var  logic flag_o
);
    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end
    // rst_val_i is a spare tied low at every instance; reset stays a constant
    wire logic unused_rst_val;
    assign unused_rst_val = rst_val_i;
endmodule
`default_nettype wire

// ===== test/secondary_pll_lock_status_tb_top.sv
// bench of the secondary pll lock status block: status reads, indicator merge, irq
// assumes one wait cycle per avalon access and the lock output one cycle behind inputs
`timescale 1ns/10ps
`default_nettype none
`include "spll_defines.svh"
module secondary_pll_lock_status_tb_top;
    logic                    clock_i = 1'b0;
    logic                    rst_b_i = 1'b0;
    logic [`SPLL_ADDR_W-1:0] address_i = '0;
    logic                    read_i = 1'b0;
    logic                    write_i = 1'b0;
    logic [31:0]             writedata_i = 32'h0;
    logic [31:0]             readdata_o;
    logic                    waitrequest_o;
    logic                    secondary_pll_locked_o;
    logic                    irq_o;
    logic [3:0]              ind = 4'h0; // fine, no-activity, freq-limit, coarse
    logic [31:0]             exp_q[$];
    int                      error_cnt = 0;
    int                      total_checks = 0;
    int                      i;
    logic [31:0]             r;

    always #5 clock_i = ~clock_i;

    spll_lock_status i_dut (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .fine_phase_loss_i(ind[0]),
        .no_activity_i(ind[1]), .freq_limit_i(ind[2]), .coarse_phase_loss_i(ind[3]),
        .secondary_pll_locked_o(secondary_pll_locked_o), .irq_o(irq_o));

    task automatic fail(input string msg);
        $display("mismatch at %0t: %s", $time, msg);
        error_cnt++;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) fail($sformatf("%s is %b expected %b", what, got, exp));
    endtask
    task automatic summarize();
        if (exp_q.size() != 0) fail("read answers missing");
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // one avalon access; entered just after a rising edge, the request is held up to the
    // rising edge at which waitrequest is sampled low, where the slave takes it
    task automatic access(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        address_i   <= {idx, 2'b00};
        writedata_i <= wr ? d : 32'h0;
        write_i     <= wr;
        read_i      <= ~wr;
        @(posedge clock_i);
        while (waitrequest_o !== 1'b0) begin
            n++;
            if (n > 50) begin
                fail("bus wait ran out");
                summarize();
            end
            @(posedge clock_i);
        end
        read_i  <= 1'b0;
        write_i <= 1'b0;
        @(posedge clock_i); // a free edge so no signal is assigned twice in one step
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        exp_q.push_back(exp);
        access(1'b0, idx, 32'h0);
    endtask
    // set indicators, let the one-cycle lock and two-cycle irq latencies pass, then look mid-cycle
    task automatic drive(input logic [3:0] v, input logic lk, input logic irq);
        ind <= v;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        chk_bit(secondary_pll_locked_o, lk, "lock");
        chk_bit(irq_o, irq, "irq");
        @(posedge clock_i);
    endtask

    // read answers are taken at the rising edge where waitrequest is low, as the master does
    always @(posedge clock_i) begin
        if (read_i && waitrequest_o === 1'b0) begin
            if (exp_q.size() == 0) fail("read answer with nothing expected");
            else chk_word(readdata_o, exp_q.pop_front());
        end
    end

    // main sequence: reset values, irq, each gated indicator, coarse hold and its release
    initial begin
        r = $urandom(51);
        repeat (16) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        rd(8'h09, 32'h40);
        rd(8'h73, 32'hc0);
        rd(8'h74, 32'h80);
        rd(8'h40, 32'h80);
        access(1'b1, 8'h55, $urandom);
        rd(8'h55, 32'h0);
        access(1'b1, 8'h81, 32'h3);
        drive(4'h1, 1'b0, 1'b1);
        rd(8'h80, 32'h1);
        drive(4'h0, 1'b1, 1'b1);
        rd(8'h80, 32'h3);
        access(1'b1, 8'h80, 32'h3);
        drive(4'h0, 1'b1, 1'b0);
        access(1'b1, 8'h81, 32'h0);
        drive(4'h1, 1'b0, 1'b0);
        rd(8'h80, 32'h1);
        for (i = 0; i < 3; i++) begin
            drive(4'h1 << i, 1'b0, 1'b0);
            rd(8'h09, 32'h0);
            drive(4'h0, 1'b1, 1'b0);
            r = (i == 0) ? 32'h40 : 32'h80;
            access(1'b1, (i == 2) ? 8'h40 : 8'h73, (i == 2) ? 32'h0 : r);
            drive(4'h1 << i, 1'b1, 1'b0);
            drive(4'h0, 1'b1, 1'b0);
            access(1'b1, (i == 2) ? 8'h40 : 8'h73, (i == 2) ? 32'h80 : 32'hc0);
        end
        drive(4'h8, 1'b0, 1'b0);
        drive(4'h0, 1'b0, 1'b0);
        rd(8'h09, 32'h0);
        access(1'b1, 8'h74, 32'h0);
        drive(4'h0, 1'b1, 1'b0);
        rd(8'h09, 32'h40);
        drive(4'h8, 1'b1, 1'b0);
        drive(4'h0, 1'b1, 1'b0);
        access(1'b1, 8'h74, 32'h80);
        rd(8'h09, 32'h40);
        summarize();
    end
endmodule
`default_nettype wire
